// File: design/mas_regs.svh
// Constants for the microcode address sequencer: fields, offsets and reset values.
`ifndef MAS_REGS_SVH
`define MAS_REGS_SVH

// Address and stack geometry.
`define MAS_ADDR_W 11
`define MAS_STACK_DEPTH 4
// Page-fault force: ones on bits 10..1, bit 0 left to the other sources.
`define MAS_FORCE_MASK 11'h7FE

// Register byte offsets on the AXI4-Lite slave.
`define MAS_OFS_CTRL 12'h000
`define MAS_OFS_LOC 12'h004
`define MAS_OFS_NEXT 12'h008
`define MAS_OFS_STAT 12'h00C
`define MAS_OFS_CREG 12'h010
`define MAS_OFS_STACK0 12'h020
`define MAS_OFS_STACK3 12'h02C

// Control register fields and reset value.
`define MAS_CTRL_RUN 0
`define MAS_CTRL_CLR 1
`define MAS_CTRL_RESET 32'h0000_0000

// AXI response codes.
`define MAS_RESP_OKAY 2'h0
`define MAS_RESP_SLVERR 2'h2

`endif

// File: design/mas_pkg.sv
// Types shared by the microcode address sequencer files.
package mas_pkg;

  // One microinstruction as it leaves the control store.
  typedef struct packed {
    logic call;        // Subroutine call control.
    logic ret;         // Subroutine return control.
    logic [10:0] jump; // Jump field, also the return modifier.
  } mas_uinstr_t;

  // Write channel handling of the register slave.
  typedef enum logic [1:0] {
    MAS_WR_IDLE = 2'h1,
    MAS_WR_RESP = 2'h2
  } mas_wr_state_t;

endpackage

// File: design/mas_stack.sv
// Four-deep pushdown stack for microsubroutine return addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mas_regs.svh"

module mas_stack #(
  parameter int WIDTH = `MAS_ADDR_W,
  parameter int DEPTH = `MAS_STACK_DEPTH
) (
  input wire logic clk, // Microcode clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic clear, // Empties the stack.
  input wire logic push, // Push push_data this edge.
  input wire logic pop, // Pop the top entry this edge.
  input wire logic [WIDTH-1:0] push_data, // Address to push.
  output logic [WIDTH*DEPTH-1:0] entries, // All entries, top in the low slice.
  output logic [2:0] depth // Number of occupied entries.
);

  // Entry storage, index 0 is the top.
  logic [WIDTH-1:0] entry [DEPTH];

  // Each entry shifts in from its neighbour; a push and pop together
  // just replace the top, which keeps a page fault on a return sane.
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          entry[i] <= '0;
        end else if (clear) begin
          entry[i] <= '0;
        end else if (push && pop) begin
          if (i == 0) begin
            entry[i] <= push_data;
          end
        end else if (push) begin
          // The deepest entry falls off the end with no warning.
          if (i == 0) begin
            entry[i] <= push_data;
          end else begin
            entry[i] <= entry[(i == 0) ? 0 : i - 1];
          end
        end else if (pop) begin
          if (i == DEPTH - 1) begin
            entry[i] <= '0;
          end else begin
            entry[i] <= entry[(i == DEPTH - 1) ? i : i + 1];
          end
        end
      end
      assign entries[i*WIDTH +: WIDTH] = entry[i];
    end
  endgenerate

  // Occupancy saturates at the depth and never goes below zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      depth <= 3'h0;
    end else if (clear) begin
      depth <= 3'h0;
    end else if (push && !pop && depth != 3'(DEPTH)) begin
      depth <= depth + 3'h1;
    end else if (pop && !push && depth != 3'h0) begin
      depth <= depth - 3'h1;
    end
  end

  // A push on a full stack leaves it full.
  full_push_a: assert property (@(posedge clk) disable iff (!reset_n)
    (push && !pop && !clear && depth == 3'(DEPTH)) |=> depth == 3'(DEPTH))
    else $error("Full stack push changed depth.");

  // The old top moves one level down on a push.
  push_shift_a: assert property (@(posedge clk) disable iff (!reset_n)
    (push && !pop && !clear) |=> entry[1] == $past(entry[0]))
    else $error("Push did not shift old top down.");

endmodule
`default_nettype wire

// File: design/mas_sequencer.sv
// Next-address sequencer with location register, return stack and register slave.
`timescale 1ns/1ps
`default_nettype none
`include "mas_regs.svh"

module mas_sequencer #(
  parameter int ADDR_W = `MAS_ADDR_W,
  parameter int DEPTH = `MAS_STACK_DEPTH
) (
  input wire logic CLK, // Microcode clock, 25 MHz.
  input wire logic RESET_N, // Asynchronous reset, active low.
  input wire mas_pkg::mas_uinstr_t CS_DATA, // Word read at CS_ADDR.
  input wire logic PAGE_FAULT, // One-cycle page fault force.
  output logic [ADDR_W-1:0] CS_ADDR, // Control store next address.
  output logic [ADDR_W-1:0] LOC, // Current location register.
  input wire logic [11:0] AWADDR, // AXI write address.
  input wire logic AWVALID, // AXI write address valid.
  output logic AWREADY, // AXI write address ready.
  input wire logic [31:0] WDATA, // AXI write data.
  input wire logic [3:0] WSTRB, // AXI write byte strobes.
  input wire logic WVALID, // AXI write data valid.
  output logic WREADY, // AXI write data ready.
  output logic [1:0] BRESP, // AXI write response.
  output logic BVALID, // AXI write response valid.
  input wire logic BREADY, // AXI write response ready.
  input wire logic [11:0] ARADDR, // AXI read address.
  input wire logic ARVALID, // AXI read address valid.
  output logic ARREADY, // AXI read address ready.
  output logic [31:0] RDATA, // AXI read data.
  output logic [1:0] RRESP, // AXI read response.
  output logic RVALID, // AXI read data valid.
  input wire logic RREADY // AXI read data ready.
);

  // Control register: run and stack clear bits.
  logic [31:0] ctrl;
  // Microinstruction currently being decoded.
  mas_pkg::mas_uinstr_t creg;
  // Current location register.
  logic [ADDR_W-1:0] current_location_reg;
  // Combinational next address.
  logic [ADDR_W-1:0] next_addr;
  // Stack contents and occupancy.
  logic [ADDR_W*DEPTH-1:0] stack_entries;
  logic [2:0] stack_depth;
  // Convenience views of the top two entries.
  logic [ADDR_W-1:0] stack_top_entry;
  logic [ADDR_W-1:0] stack_second_entry;
  // Decoded stack controls.
  logic subroutine_call_ctl;
  logic subroutine_return_ctl;
  // Sequencing runs only while software allows it.
  logic run;
  logic stack_clear;

  assign run = ctrl[`MAS_CTRL_RUN];
  assign stack_clear = ctrl[`MAS_CTRL_CLR];
  assign stack_top_entry = stack_entries[ADDR_W-1:0];
  assign stack_second_entry = stack_entries[2*ADDR_W-1:ADDR_W];

  // Only two controls move the stack; the page fault borrows the call
  // control so the interrupted address is saved.
  assign subroutine_call_ctl = run && (creg.call || PAGE_FAULT);
  assign subroutine_return_ctl = run && creg.ret;

  // The address lines are OR gates: any true source sets a bit. The
  // jump field is always a source, the stack top joins on a return and
  // the force mask joins on a page fault.
  always_comb begin
    next_addr = creg.jump;
    if (creg.ret) begin
      next_addr = next_addr | stack_top_entry;
    end
    if (PAGE_FAULT) begin
      next_addr = next_addr | `MAS_FORCE_MASK;
    end
  end

  // The address is a gate output by nature, so it is not registered.
  assign CS_ADDR = next_addr;
  assign LOC = current_location_reg;

  // Location register: takes the next address each running clock, but the
  // modifier alone on a return, as the stack holds the base.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      current_location_reg <= '0;
    end else if (run) begin
      if (creg.ret) begin
        current_location_reg <= creg.jump;
      end else begin
        current_location_reg <= next_addr;
      end
    end
  end

  // Control register loads the word fetched at the next address.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      creg <= '0;
    end else if (run) begin
      creg <= CS_DATA;
    end
  end

  // Return stack, pushed with the current location.
  mas_stack #(
    .WIDTH(ADDR_W),
    .DEPTH(DEPTH)
  ) u_stack (
    .clk(CLK),
    .reset_n(RESET_N),
    .clear(stack_clear),
    .push(subroutine_call_ctl),
    .pop(subroutine_return_ctl),
    .push_data(current_location_reg),
    .entries(stack_entries),
    .depth(stack_depth)
  );

  // AXI4-Lite write side.
  // Address and data are caught separately so either may come first.
  mas_pkg::mas_wr_state_t wr_state;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;

  assign AWREADY = !aw_held && wr_state == mas_pkg::MAS_WR_IDLE;
  assign WREADY = !w_held && wr_state == mas_pkg::MAS_WR_IDLE;
  assign BVALID = wr_state == mas_pkg::MAS_WR_RESP;
  assign wr_go = aw_held && w_held && wr_state == mas_pkg::MAS_WR_IDLE;

  // Capture the write address.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (AWVALID && AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= AWADDR;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  // Capture the write data and strobes.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (WVALID && WREADY) begin
      w_held <= 1'b1;
      w_data <= WDATA;
      w_strb <= WSTRB;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // Write state: perform the write, then hold the response.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_state <= mas_pkg::MAS_WR_IDLE;
      BRESP <= `MAS_RESP_OKAY;
    end else begin
      case (wr_state)
        mas_pkg::MAS_WR_IDLE: begin
          if (wr_go) begin
            wr_state <= mas_pkg::MAS_WR_RESP;
            // Only the control word is writable.
            if (aw_addr == `MAS_OFS_CTRL) begin
              BRESP <= `MAS_RESP_OKAY;
            end else begin
              BRESP <= `MAS_RESP_SLVERR;
            end
          end
        end
        mas_pkg::MAS_WR_RESP: begin
          if (BREADY) begin
            wr_state <= mas_pkg::MAS_WR_IDLE;
          end
        end
        default: begin
          wr_state <= mas_pkg::MAS_WR_IDLE;
        end
      endcase
    end
  end

  // Control register, written byte by byte through the strobes.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= `MAS_CTRL_RESET;
    end else if (wr_go && aw_addr == `MAS_OFS_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
        end
      end
    end
  end

  // AXI4-Lite read side.
  // Diagnostic readback mux over the sequencing state.
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [1:0] rd_slot;

  assign rd_slot = ARADDR[3:2];

  // Unmapped reads answer zero with a slave error.
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ARADDR == `MAS_OFS_CTRL) begin
      rd_mux = ctrl;
    end else if (ARADDR == `MAS_OFS_LOC) begin
      rd_mux = 32'(current_location_reg);
    end else if (ARADDR == `MAS_OFS_NEXT) begin
      rd_mux = 32'(next_addr);
    end else if (ARADDR == `MAS_OFS_STAT) begin
      rd_mux = {27'h0, PAGE_FAULT, subroutine_call_ctl, stack_depth};
    end else if (ARADDR == `MAS_OFS_CREG) begin
      rd_mux = 32'(creg);
    end else if (ARADDR >= `MAS_OFS_STACK0 && ARADDR <= `MAS_OFS_STACK3
                 && ARADDR[1:0] == 2'h0) begin
      rd_mux = 32'(stack_entries[32'(rd_slot)*ADDR_W +: ADDR_W]);
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign ARREADY = !RVALID;

  // Read answer registered one cycle after the address is taken.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= `MAS_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA <= rd_mux;
      RRESP <= rd_hit ? `MAS_RESP_OKAY : `MAS_RESP_SLVERR;
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // Checks on the sequencing behaviour.
  // A call in the decode stage saves the location and shifts the top.
  sequence call_decoded_s;
    run && creg.call && !creg.ret && !stack_clear;
  endsequence

  sequence push_landed_s;
    stack_top_entry == $past(current_location_reg)
      && stack_second_entry == $past(stack_top_entry);
  endsequence

  call_push_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    call_decoded_s |=> push_landed_s)
    else $error("Call did not push the location.");

  // Each running clock without a return the location takes the next address.
  loc_capture_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (run && !creg.ret) |=> current_location_reg == $past(CS_ADDR))
    else $error("Location missed the next address.");

  // The fetched word becomes the decoded word.
  creg_load_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    run |=> creg == $past(CS_DATA))
    else $error("Control register missed the fetched word.");

  // A return drives top OR modifier when no fault is present.
  ret_addr_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (creg.ret && !PAGE_FAULT) |-> CS_ADDR == (stack_top_entry | creg.jump))
    else $error("Return address is not top OR modifier.");

  // A return pops the stack and latches only the modifier.
  ret_pop_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (run && creg.ret && !creg.call && !PAGE_FAULT && !stack_clear)
      |=> stack_top_entry == $past(stack_second_entry))
    else $error("Return did not pop the stack.");

  ret_loc_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (run && creg.ret) |=> current_location_reg == $past(creg.jump))
    else $error("Return did not load the modifier.");

  // A fault forces bits 10..1 high and leaves bit 0 to the jump field and, on a return, the stack top.
  pf_force_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    PAGE_FAULT |-> (CS_ADDR[10:1] == 10'h3FF
      && CS_ADDR[0] == (creg.jump[0] | (creg.ret & stack_top_entry[0]))))
    else $error("Page fault force pattern wrong.");

  // A fault pushes the interrupted location.
  pf_push_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (run && PAGE_FAULT && !creg.ret && !stack_clear)
      |=> stack_top_entry == $past(current_location_reg))
    else $error("Page fault did not push the location.");

  // The write response stands until taken.
  bresp_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (BVALID && !BREADY) |=> BVALID && $stable(BRESP))
    else $error("Write response dropped early.");

endmodule
`default_nettype wire

// File: dv/mas_cstore_model.sv
// Control store model that answers each next address with a word of a fixed program.
`timescale 1ns/1ps
`default_nettype none

module mas_cstore_model (
  input wire logic [10:0] addr, // Next address from the sequencer.
  output wire mas_pkg::mas_uinstr_t data // Word stored at that address.
);
  mas_pkg::mas_uinstr_t mem [0:2047]; // Store contents.

  // Builds one word from its call, return and jump fields.
  function automatic mas_pkg::mas_uinstr_t word(input logic c, input logic r,
                                                input logic [10:0] j);
    word = '{call: c, ret: r, jump: j};
  endfunction

  // Odd call sites and overlapping modifiers make an OR differ from an add.
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = word(1'b0, 1'b0, 11'h000);
    end
    mem[11'h000] = word(1'b1, 1'b0, 11'h105); // Outer call.
    mem[11'h105] = word(1'b1, 1'b0, 11'h2A0); // Nested call.
    mem[11'h2A0] = word(1'b0, 1'b1, 11'h003); // Return with modifier 3.
    mem[11'h107] = word(1'b0, 1'b1, 11'h010); // Return to the outer caller.
    mem[11'h010] = word(1'b0, 1'b0, 11'h301); // Jump to an odd idle loop.
    mem[11'h301] = word(1'b0, 1'b0, 11'h301); // Idle loop, waits for a fault.
    mem[11'h7FF] = word(1'b0, 1'b1, 11'h004); // Fault handler returns at once.
    mem[11'h305] = word(1'b1, 1'b0, 11'h311); // Five calls overfill the stack.
    for (int i = 11'h311; i < 11'h315; i++) begin
      mem[i] = word(1'b1, 1'b0, 11'(i + 1));
    end
    mem[11'h315] = word(1'b0, 1'b0, 11'h315); // Final idle loop.
  end

  // The word follows the address in the same cycle, as a real store read does.
  assign data = mem[addr];
endmodule
`default_nettype wire

// File: dv/mas_sequencer_tb_top.sv
// Self-checking testbench for the microcode address sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "mas_regs.svh"

module mas_sequencer_tb_top;
  logic clk = 1'b0; // Microcode clock.
  logic reset_n = 1'b0; // Reset, active low.
  logic page_fault = 1'b0; // Page fault force.
  mas_pkg::mas_uinstr_t cs_data; // Word from the store model.
  logic [10:0] cs_addr; // Next address.
  logic [10:0] loc; // Current location.
  logic [11:0] awaddr = 12'h000; // Write address.
  logic awvalid = 1'b0; // Write address valid.
  logic awready; // Write address ready.
  logic [31:0] wdata = 32'h0000_0000; // Write data.
  logic [3:0] wstrb = 4'hF; // Write strobes.
  logic wvalid = 1'b0; // Write data valid.
  logic wready; // Write data ready.
  logic [1:0] bresp; // Write response.
  logic bvalid; // Write response valid.
  logic bready = 1'b0; // Write response ready.
  logic [11:0] araddr = 12'h000; // Read address.
  logic arvalid = 1'b0; // Read address valid.
  logic arready; // Read address ready.
  logic [31:0] rdata; // Read data.
  logic [1:0] rresp; // Read response.
  logic rvalid; // Read valid.
  logic rready = 1'b0; // Read ready.
  int num_errors = 0; // Mismatches seen.
  int cmp_count = 0; // Comparisons made.
  int cycles = 0; // Watchdog count.
  logic [10:0] addr_q[$]; // Each new next address.
  logic [10:0] loc_q[$]; // Each new location.
  logic [10:0] exp_addr[13] = '{11'h000, 11'h105, 11'h2A0, 11'h107, 11'h010, 11'h301,
    11'h7FF, 11'h305, 11'h311, 11'h312, 11'h313, 11'h314, 11'h315}; // Expected flow.
  // A return loads only its modifier, so the location skips the address it returned to.
  logic [10:0] exp_loc[13] = '{11'h000, 11'h105, 11'h2A0, 11'h003, 11'h010, 11'h301,
    11'h7FF, 11'h004, 11'h311, 11'h312, 11'h313, 11'h314, 11'h315}; // Locations.

  // The clock toggles every 20 ns, half of its 40 ns period.
  always #20 clk = ~clk;

  mas_sequencer DUT (.CLK(clk), .RESET_N(reset_n), .CS_DATA(cs_data),
    .PAGE_FAULT(page_fault), .CS_ADDR(cs_addr), .LOC(loc), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready));

  mas_cstore_model cs (.addr(cs_addr), .data(cs_data));

  // Compares two values and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the hundred or so cycles the run needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      $display("Error at %0t: cycle count %h reached limit %h", $time, cycles, 5000);
      end_of_test();
    end
  end

  // Logs each change so that the whole flow is judged after the run.
  always @(negedge clk) begin
    if (reset_n && (addr_q.size() == 0 || addr_q[$] !== cs_addr)) begin
      addr_q.push_back(cs_addr);
    end
    if (reset_n && (loc_q.size() == 0 || loc_q[$] !== loc)) begin
      loc_q.push_back(loc);
    end
  end

  // One register write; address and data are each released when taken.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    check({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask

  // One register read; the answer is taken at the edge where valid is seen.
  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask

  // Main sequence of tests.
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    axi_read(`MAS_OFS_CTRL, `MAS_CTRL_RESET, `MAS_RESP_OKAY);
    axi_read(`MAS_OFS_LOC, 32'h0, `MAS_RESP_OKAY);
    axi_read(12'h040, 32'h0, `MAS_RESP_SLVERR);
    $display("Test reset and map done");
    axi_write(`MAS_OFS_CTRL, 32'h1, `MAS_RESP_OKAY);
    axi_write(`MAS_OFS_LOC, 32'h7, `MAS_RESP_SLVERR);
    axi_read(`MAS_OFS_CTRL, 32'h1, `MAS_RESP_OKAY);
    while (loc !== 11'h301) @(posedge clk);
    $display("Test calls and returns done");
    repeat (3) @(posedge clk);
    page_fault <= 1'b1;
    @(negedge clk);
    check({21'h0, cs_addr}, 32'h7FF);
    @(posedge clk);
    page_fault <= 1'b0;
    while (loc !== 11'h315) @(posedge clk);
    repeat (2) @(posedge clk);
    $display("Test page fault done");
    axi_read(`MAS_OFS_STAT, 32'h4, `MAS_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      axi_read(12'(`MAS_OFS_STACK0 + 4 * i), 32'(12'h314 - i), `MAS_RESP_OKAY);
    end
    axi_read(`MAS_OFS_NEXT, 32'h315, `MAS_RESP_OKAY);
    axi_read(`MAS_OFS_CREG, 32'h315, `MAS_RESP_OKAY);
    axi_write(`MAS_OFS_CTRL, 32'h3, `MAS_RESP_OKAY);
    axi_write(`MAS_OFS_CTRL, 32'h1, `MAS_RESP_OKAY);
    axi_read(`MAS_OFS_STAT, 32'h0, `MAS_RESP_OKAY);
    // Byte lane 0 is masked off, so the run bit must survive a write of zero.
    wstrb <= 4'hE;
    axi_write(`MAS_OFS_CTRL, 32'h0, `MAS_RESP_OKAY);
    axi_read(`MAS_OFS_CTRL, 32'h1, `MAS_RESP_OKAY);
    $display("Test overflow and readback done");
    check(addr_q.size(), 13);
    check(loc_q.size(), 13);
    for (int i = 0; i < 13 && i < addr_q.size(); i++) begin
      check({21'h0, addr_q[i]}, {21'h0, exp_addr[i]});
    end
    for (int i = 0; i < 13 && i < loc_q.size(); i++) begin
      check({21'h0, loc_q[i]}, {21'h0, exp_loc[i]});
    end
    $display("Test address flow done");
    end_of_test();
  end
endmodule
`default_nettype wire
